// File: include/isw_pkg.sv
// Constants and types for the two-wire switch control slave port.
// ============================================================
// Behaviour
// - One data bit moves per serial clock pulse.
// - Data stable while clock high; changes then are control conditions.
// - Both lines sit high when idle; nobody pulls them low.
// - Data falling while clock high is START; address reception restarts.
// - Data rising while clock high is STOP; return to idle.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Any number of bytes accepted between START and STOP.
// - Addressed receiving device acknowledges address and every written byte.
// - Acknowledger drives low before clock rises, holds through high.
// - After read not-acknowledge the device releases data for STOP.
// - Write transaction: START, address with direction zero, data bytes.
// - Read transaction returns current control register as channel status.
// - Glitches of 50 ns or less on clock and data are ignored.
// - Data sampling or changing delayed at least 300 ns after clock falls.
// - Last address bit is direction: one read, zero write.
// - Of several written bytes only the last is kept.
// - New selection reaches channel enables only at the next STOP.
// - Reset pin or power-on clears register, channels and state machine; here only resetn_in clears them, with no power-on clear of its own.
package isw_pkg;

	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SPIKE_NS      = 50;
	localparam int HOLD_NS       = 300;
	// Filter needs agreement over more than the spike width.
	localparam int FLT_CYCLES    = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int HOLD_CYCLES   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ============================================================
	// Addressing and reset values
	localparam logic [3:0] ADDR_FIXED = 4'hE;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int         BIT_LAST   = 7;

	// ============================================================
	// States
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_WDATA = 6'h04,
		ST_RDATA = 6'h08,
		ST_ACK   = 6'h10,
		ST_MACK  = 6'h20
	} isw_state_t;

endpackage

// File: verilog/isw_glitch_filter.sv
// Synchroniser and spike filter for one serial input.
`timescale 1ns/1ps
module isw_glitch_filter
	import isw_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Line
	input  wire logic line_in,
	output logic      line_out
);
	logic       sync1_r;
	logic       sync2_r;
	logic [3:0] cnt_r;

	// ============================================================
	// Two-flop synchroniser, then a run-length filter.
	// The filter costs a few cycles of latency, far below bus bit times.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sync1_r  <= 1'b1;
			sync2_r  <= 1'b1;
			cnt_r    <= 4'h0;
			line_out <= 1'b1;
		end
		else
		begin
			sync1_r <= line_in;
			sync2_r <= sync1_r;
			if (sync2_r == line_out)
				cnt_r <= 4'h0;
			else if (cnt_r == 4'(FLT_CYCLES - 1))
			begin
				cnt_r    <= 4'h0;
				line_out <= sync2_r;
			end
			else
				cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// File: verilog/isw_slave_port.sv
// Two-wire slave port holding the channel-select control byte.
`timescale 1ns/1ps
module isw_slave_port
	import isw_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// Serial bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Address select pins
	input  wire logic       addr_sel_0_in,
	input  wire logic       addr_sel_1_in,
	input  wire logic       addr_sel_2_in,
	// Channel enables
	output logic [7:0]      chan_en_out
);
	logic       scl_f;
	logic       sda_f;
	logic       scl_d_r;
	logic       sda_d_r;
	logic [2:0] asel_s1_r;
	logic [2:0] asel_s2_r;
	isw_state_t state_r;
	logic [2:0] bitcnt_r;
	logic [7:0] shift_r;
	logic [7:0] ctrl_r;
	logic       pend_r;
	logic       rd_r;
	logic       drive_r;
	logic [3:0] hold_r;
	logic       ack_low_r;

	isw_glitch_filter u_flt_scl (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.line_in   (scl_in),
		.line_out  (scl_f)
	);
	isw_glitch_filter u_flt_sda (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.line_in   (sda_in),
		.line_out  (sda_f)
	);

	// ============================================================
	// Condition and edge decode
	wire scl_rise  = scl_f & ~scl_d_r;
	wire scl_fall  = ~scl_f & scl_d_r;
	wire start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
	wire stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;
	wire [7:0] rx_byte = {shift_r[6:0], sda_f};
	wire addr_hit  = (rx_byte[7:4] == ADDR_FIXED) &&
		(rx_byte[3:1] == asel_s2_r);
	wire hold_done = (hold_r == 4'h0);
	wire byte_end  = (bitcnt_r == 3'(BIT_LAST));
	// Outgoing read bit, driven one hold period after clock falls, so the previous bit keeps its hold time.
	wire out_bit   = shift_r[7];

	assign sda_out    = 1'b0;
	assign sda_oe_out = drive_r;

	// ============================================================
	// Input registers
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			scl_d_r   <= 1'b1;
			sda_d_r   <= 1'b1;
			asel_s1_r <= 3'h0;
			asel_s2_r <= 3'h0;
		end
		else
		begin
			scl_d_r   <= scl_f;
			sda_d_r   <= sda_f;
			asel_s1_r <= {addr_sel_2_in, addr_sel_1_in, addr_sel_0_in};
			asel_s2_r <= asel_s1_r;
		end
	end

	// ============================================================
	// Hold timer after each clock fall.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			hold_r <= 4'h0;
		else if (scl_fall)
			hold_r <= 4'(HOLD_CYCLES);
		else if (!hold_done)
			hold_r <= hold_r - 4'h1;
	end

	// ============================================================
	// Protocol engine
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r     <= ST_IDLE;
			bitcnt_r    <= 3'h0;
			shift_r     <= 8'h00;
			ctrl_r      <= CTRL_RESET;
			pend_r      <= 1'b0;
			rd_r        <= 1'b0;
			drive_r     <= 1'b0;
			ack_low_r   <= 1'b0;
			chan_en_out <= CTRL_RESET;
		end
		else if (stop_det)
		begin
			state_r <= ST_IDLE;
			drive_r <= 1'b0;
			if (pend_r)
				chan_en_out <= ctrl_r;
			pend_r  <= 1'b0;
		end
		else if (start_det)
		begin
			state_r  <= ST_ADDR;
			bitcnt_r <= 3'h0;
			drive_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
			ST_ADDR, ST_WDATA:
			begin
				// An acknowledge pull-down is let go only once the hold time has run out.
				if (hold_done && !scl_f && !scl_d_r)
					drive_r <= 1'b0;
				if (scl_rise)
				begin
					shift_r  <= rx_byte;
					bitcnt_r <= bitcnt_r + 3'h1;
					if (byte_end)
					begin
						if (state_r == ST_ADDR)
						begin
							if (addr_hit)
							begin
								rd_r    <= rx_byte[0];
								state_r <= ST_ACK;
							end
							else
								state_r <= ST_IDLE;
						end
						else
						begin
							ctrl_r  <= rx_byte;
							pend_r  <= 1'b1;
							state_r <= ST_ACK;
						end
					end
				end
			end
			ST_ACK:
			begin
				// Pull low after the hold time past the fall that ends bit eight.
				if (!scl_f && hold_done && !ack_low_r && !scl_d_r)
				begin
					drive_r   <= 1'b1;
					ack_low_r <= 1'b1;
				end
				else if (ack_low_r && scl_fall)
				begin
					// Still pulling here; dropping it on the fall would break the hold time.
					ack_low_r <= 1'b0;
					bitcnt_r  <= 3'h0;
					if (rd_r)
					begin
						shift_r <= ctrl_r;
						state_r <= ST_RDATA;
					end
					else
						state_r <= ST_WDATA;
				end
			end
			ST_RDATA:
			begin
				if (!scl_f && hold_done && !scl_d_r)
					drive_r <= ~out_bit;
				if (scl_fall)
				begin
					shift_r  <= {shift_r[6:0], 1'b0};
					bitcnt_r <= bitcnt_r + 3'h1;
					if (byte_end)
						state_r <= ST_MACK;
				end
			end
			ST_MACK:
			begin
				if (hold_done)
					drive_r <= 1'b0;
				if (scl_rise)
				begin
					if (sda_f)
						state_r <= ST_IDLE;
					else
					begin
						shift_r  <= ctrl_r;
						bitcnt_r <= 3'h0;
					end
				end
				else if (scl_fall && !sda_f)
					state_r <= ST_RDATA;
			end
			default:
			begin
				drive_r <= 1'b0;
			end
			endcase
		end
	end
endmodule

// File: tb/isw_slave_port_asserts.sv
// Pin-level checker for the two-wire slave port.
`timescale 1ns/1ps
module isw_slave_port_asserts
(
	// Clock and reset
	input	wire logic			clk_in,
	input	wire logic			resetn_in,
	// Serial bus and enables
	input	wire logic			scl_in,
	input	wire logic			sda_in,
	input	wire logic			sda_out,
	input	wire logic			sda_oe_out,
	input	wire logic [7:0]	chan_en_out
);
	// ============================================================
	// Properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_start;
		scl_in && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence
	property p_reset_clear;
		disable iff (1'b0) !resetn_in |-> !sda_oe_out && chan_en_out == 8'h00;
	endproperty
	property p_sda_low;
		sda_out == 1'b0;
	endproperty
	property p_chan_at_stop;
		$changed(chan_en_out) |-> scl_in && sda_in && $past(scl_in, 4);
	endproperty
	property p_oe_scl_low;
		$changed(sda_oe_out) |-> !scl_in;
	endproperty
	property p_hold;
		$fell(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe_out)[*8];
	endproperty
	property p_ack_held;
		$rose(sda_oe_out) |=> sda_oe_out[*8];
	endproperty
	property p_stop_release;
		s_stop |-> !sda_oe_out[*8];
	endproperty
	property p_start_quiet;
		s_start |-> !sda_oe_out[*8];
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left outputs set");
	a_sda_low: assert property (p_sda_low) else $error("data output not low");
	a_chan_at_stop: assert property (p_chan_at_stop) else $error("enables moved off stop");
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
	a_hold: assert property (p_hold) else $error("data hold too short");
	a_ack_held: assert property (p_ack_held) else $error("pull-down too short");
	a_stop_release: assert property (p_stop_release) else $error("driving after stop");
	a_start_quiet: assert property (p_start_quiet) else $error("driving after start");
endmodule

// File: tb/isw_master_model.sv
// Behavioural two-wire bus master facing the slave port.
`timescale 1ns/1ps
module isw_master_model
(
	// Clock and line
	input	wire logic	clk_in,
	input	wire logic	sda_in,
	// Drive
	output	logic		scl_out = 1'b1,
	output	logic		sda_oe_out = 1'b0
);
	logic glitch = 1'b0;
	// ============================================================
	// Bus cycles
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Low phase is stretched so the slave's 300 ns hold fits inside it.
	task automatic bit_io(input logic b, input logic gl, output logic s);
		scl_out = 1'b0;
		wait_clk(8);
		sda_oe_out = !b;
		if (gl)
		begin
			wait_clk(1);
			scl_out = 1'b1;
			wait_clk(1);
			scl_out = 1'b0;
		end
		wait_clk(12);
		scl_out = 1'b1;
		wait_clk(2);
		s = sda_in;
		wait_clk(2);
	endtask
	task automatic start();
		sda_oe_out = 1'b1;
		wait_clk(8);
	endtask
	task automatic stop();
		logic s;
		bit_io(1'b0, 1'b0, s);
		sda_oe_out = 1'b0;
		wait_clk(40);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], glitch, q[i]);
		bit_io(ak, 1'b0, a);
	endtask
endmodule

// File: tb/test_isw_slave_port.sv
// Top testbench for the two-wire switch control slave port.
`timescale 1ns/1ps
module test_isw_slave_port;
	logic		clk_in = 1'b0;
	logic		resetn_in = 1'b1;
	logic		scl;
	logic		m_oe;
	logic		dut_oe;
	logic		sda_zero;
	logic [2:0]	sel = 3'h5;
	logic [7:0]	chan;
	logic [7:0]	q;
	logic		ack;
	int			bad_count = 0;
	int			check_count = 0;
	wire		sda_line = !(m_oe || dut_oe);
	wire [7:0]	aw = {isw_pkg::ADDR_FIXED, sel, 1'b0};
	always #20 clk_in = !clk_in;
	isw_master_model m (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(m_oe));
	isw_slave_port dut (.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_zero), .sda_oe_out(dut_oe), .addr_sel_0_in(sel[0]),
		.addr_sel_1_in(sel[1]), .addr_sel_2_in(sel[2]), .chan_en_out(chan));
	// ============================================================
	// Scenarios
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_write();
		m.start();
		m.xfer(aw, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		m.xfer(8'h5A, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		m.xfer(8'hC3, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		check(chan, 8'h00);
		m.stop();
		check(chan, 8'hC3);
	endtask
	task automatic t_read();
		m.start();
		m.xfer(aw | 8'h01, 1'b1, q, ack);
		check(8'(ack), 8'h00);
		m.xfer(8'hFF, 1'b0, q, ack);
		check(q, 8'hC3);
		m.xfer(8'hFF, 1'b1, q, ack);
		check(q, 8'hC3);
		m.stop();
		check(8'(dut_oe), 8'h00);
		check(chan, 8'hC3);
	endtask
	task automatic t_refuse();
		m.start();
		m.xfer(aw ^ 8'h04, 1'b1, q, ack);
		check(8'(ack), 8'h01);
		m.xfer(8'h00, 1'b1, q, ack);
		m.stop();
		check(chan, 8'hC3);
	endtask
	// Spikes go into every address and data bit, where a shifted count would corrupt the byte.
	task automatic t_glitch();
		sel = 3'h2;
		m.wait_clk(4);
		m.glitch = 1'b1;
		m.start();
		m.xfer(aw, 1'b1, q, ack);
		m.xfer(8'h81, 1'b1, q, ack);
		m.glitch = 1'b0;
		m.stop();
		check(chan, 8'h81);
	endtask
	task automatic t_reset();
		m.start();
		m.xfer(aw, 1'b1, q, ack);
		resetn_in = 1'b0;
		m.wait_clk(3);
		check(chan, 8'h00);
		check(8'(dut_oe), 8'h00);
		resetn_in = 1'b1;
		m.wait_clk(10);
		m.stop();
	endtask
	initial
	begin
		#1 resetn_in = 1'b0;
		m.wait_clk(3);
		resetn_in = 1'b1;
		m.wait_clk(10);
		t_write();
		t_read();
		t_refuse();
		t_glitch();
		t_reset();
		t_write();
		close_out();
	end
	initial
	begin
		repeat (100000) @(posedge clk_in);
		bad_count++;
		close_out();
	end
endmodule
bind isw_slave_port isw_slave_port_asserts chk (.clk_in(clk_in), .resetn_in(resetn_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.chan_en_out(chan_en_out));
